// File: pkg/frame_pkg.sv
// constants and state types shared by both ends of the character link
package frame_pkg;
   localparam int unsigned ETU_W        = 16;      // width of the cycles-per-unit count
   localparam logic [3:0]  PARITY_BIT   = 4'h9;    // rank of the parity bit in a character
   localparam logic [3:0]  GUARD_ETU    = 4'h2;    // idle units after each sent character
   localparam logic [7:0]  CONV_DIRECT  = 8'h3B;   // convention char meaning lsb first
   localparam logic [7:0]  CONV_INVERSE = 8'h3F;   // convention char meaning msb first
   localparam logic        LINE_HIGH    = 1'b1;    // idle level of the shared line

   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_SEND  = 2'b01,
      TX_GUARD = 2'b10
   } tx_state_t;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_RUN  = 2'b01,
      RX_WAIT = 2'b10
   } rx_state_t;
endpackage

// File: pkg/frame_if.sv
// shared single-wire line: open-drain drivers of both ends and the resolved level
`timescale 1ns/1ps
`default_nettype none
interface frame_if;
   logic card_out;
   logic card_oe_n;
   logic term_out;
   logic term_oe_n;
   logic io_level;

   // wired-and with pull-up: a side only pulls low while its enable is low
   assign io_level = (card_oe_n | card_out) & (term_oe_n | term_out);

   modport card (output card_out, output card_oe_n, input io_level);
   modport term (output term_out, output term_oe_n, input io_level);
endinterface
`default_nettype wire

// File: core/card_device_end.sv
// card end of the character link: framing, parity, timing and bit order
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - transmit only after seeing line high
// - ten bits: low start, eight data, parity
// - parity makes total ones count even
// - start bit confirmed within 0.7 unit
// - sample bit n at n+0.5 units
// - bit n ends at n+1 units
// - start spacing is ten units plus guard
// - nobody drives the line during guard; only the sender's own driver keeps to it, the other end may start then
// - multi-byte values go most significant first
// - convention char fixes bit order for both
// - card tolerates terminal edges 0.2 off
module card_device_end (
   input  wire logic                        CORE_CLK,
   input  wire logic                        RESET,
   frame_if.card                            LINK,
   input  wire logic [frame_pkg::ETU_W-1:0] ETU_CYCLES,
   input  wire logic                        MSB_FIRST,
   input  wire logic [7:0]                  TX_DATA,
   input  wire logic                        TX_VALID,
   output logic                             TX_READY,
   output logic [7:0]                       RX_DATA,
   output logic                             RX_VALID,
   output logic                             RX_PARITY_ERR,
   output logic                             ORDER_MSB
);

   ////////////////////////////////////////////////////////////////////////////
   // strap capture and convention character
   logic cap_q;
   logic msb_q;
   logic pend_q;

   // strap is caught on the first edge after reset release, never by the reset
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         cap_q <= 1'b0;
         msb_q <= 1'b0;
      end else if (!cap_q) begin
         cap_q <= 1'b1;
         msb_q <= MSB_FIRST;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // shared decode
   logic                        line;
   logic                        prev_q;
   logic                        fall;
   logic [frame_pkg::ETU_W-1:0] etu_last;
   logic [frame_pkg::ETU_W-1:0] etu_half;
   logic [7:0]                  conv_char;
   logic [7:0]                  tx_byte;

   assign line      = LINK.io_level;
   assign fall      = prev_q & ~line;
   assign etu_last  = ETU_CYCLES - 16'h0001;
   assign etu_half  = ETU_CYCLES >> 1;                        // 0.5 unit, inside the 0.7 window
   assign conv_char = msb_q ? frame_pkg::CONV_INVERSE : frame_pkg::CONV_DIRECT;
   assign tx_byte   = pend_q ? conv_char : TX_DATA;

   ////////////////////////////////////////////////////////////////////////////
   // transmitter
   frame_pkg::tx_state_t        tx_q;
   frame_pkg::tx_state_t        tx_d;
   logic [frame_pkg::ETU_W-1:0] tcnt_q;
   logic [3:0]                  tbit_q;
   logic [7:0]                  tsh_q;
   logic                        tpar_q;
   logic                        t_end;
   logic                        t_go;
   logic                        t_level;
   logic                        rx_busy;
   logic [7:0]                  tx_order;
   logic [7:0]                  tx_rev;

   assign t_end    = (tcnt_q == etu_last);
   // a new start bit only when the line is seen high and no frame is coming in
   assign t_go     = TX_READY & (pend_q | TX_VALID) & line & ~rx_busy;
   assign tx_rev   = {<<{tx_byte}};
   assign tx_order = msb_q ? tx_rev : tx_byte;
   // start low, data in send order, then even parity
   assign t_level  = (tbit_q == 4'h0) ? 1'b0 :
                     (tbit_q == frame_pkg::PARITY_BIT) ? tpar_q : tsh_q[0];

   // next transmit state
   always_comb begin
      tx_d = tx_q;
      case (tx_q)
         frame_pkg::TX_IDLE: begin
            if (t_go) begin
               tx_d = frame_pkg::TX_SEND;
            end
         end
         frame_pkg::TX_SEND: begin
            if (t_end && tbit_q == frame_pkg::PARITY_BIT) begin
               tx_d = frame_pkg::TX_GUARD;
            end
         end
         frame_pkg::TX_GUARD: begin
            if (t_end && tbit_q == frame_pkg::GUARD_ETU - 4'h1) begin
               tx_d = frame_pkg::TX_IDLE;
            end
         end
         default: tx_d = frame_pkg::TX_IDLE;
      endcase
   end

   // bit timer: every edge lands on a whole unit from the start edge
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         tx_q   <= frame_pkg::TX_IDLE;
         tcnt_q <= 16'h0000;
         tbit_q <= 4'h0;
      end else begin
         tx_q <= tx_d;
         // the taking edge is the first cycle of the start bit
         if (t_go) begin
            tcnt_q <= 16'h0001;
         end else if (tx_q == frame_pkg::TX_IDLE || t_end) begin
            tcnt_q <= 16'h0000;
         end else begin
            tcnt_q <= tcnt_q + 16'h0001;
         end
         if (tx_q != tx_d) begin
            tbit_q <= 4'h0;
         end else if (t_end) begin
            tbit_q <= tbit_q + 4'h1;
         end
      end
   end

   // data shift and parity; bytes go out in the order handed in
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         tsh_q  <= 8'h00;
         tpar_q <= 1'b0;
         pend_q <= 1'b1;
      end else if (t_go) begin
         tsh_q  <= tx_order;
         tpar_q <= ^tx_byte;
         pend_q <= 1'b0;
      end else if (tx_q == frame_pkg::TX_SEND && t_end && tbit_q != 4'h0) begin
         tsh_q <= {1'b0, tsh_q[7:1]};
      end
   end

   // line driver: released outside the ten bits, so the guard stays high
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         LINK.card_out  <= 1'b0;
         LINK.card_oe_n <= 1'b1;
         TX_READY       <= 1'b0;
         ORDER_MSB      <= 1'b0;
      end else begin
         LINK.card_out  <= 1'b0;
         // the bit counter runs one cycle ahead, so every bit lasts a whole unit
         LINK.card_oe_n <= ~(t_go | (tx_q == frame_pkg::TX_SEND & ~t_level));
         TX_READY       <= cap_q & (tx_d == frame_pkg::TX_IDLE) & ~t_go;
         ORDER_MSB      <= msb_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receiver
   frame_pkg::rx_state_t        rx_q;
   frame_pkg::rx_state_t        rx_d;
   logic [frame_pkg::ETU_W-1:0] rcnt_q;
   logic [3:0]                  rbit_q;
   logic [7:0]                  rsh_q;
   logic                        r_samp;
   logic                        r_end;
   logic                        r_fail;
   logic                        r_done;
   logic [7:0]                  rx_rev;

   assign rx_busy = (rx_q != frame_pkg::RX_IDLE);
   assign r_samp  = (rx_q == frame_pkg::RX_RUN) && (rcnt_q == etu_half);
   assign r_end   = (rcnt_q == etu_last);
   // a glitch shorter than half a unit is dropped, not taken as a start
   assign r_fail  = r_samp && (rbit_q == 4'h0) && line;
   assign r_done  = r_samp && (rbit_q == frame_pkg::PARITY_BIT);
   assign rx_rev  = {<<{rsh_q}};

   // next receive state; own transmission is not heard
   always_comb begin
      rx_d = rx_q;
      case (rx_q)
         frame_pkg::RX_IDLE: begin
            if (fall && tx_q == frame_pkg::TX_IDLE && !t_go) begin
               rx_d = frame_pkg::RX_RUN;
            end
         end
         frame_pkg::RX_RUN: begin
            if (r_fail || r_done) begin
               rx_d = frame_pkg::RX_WAIT;
            end
         end
         frame_pkg::RX_WAIT: begin
            if (line) begin
               rx_d = frame_pkg::RX_IDLE;
            end
         end
         default: rx_d = frame_pkg::RX_IDLE;
      endcase
   end

   // mid-bit sampling keeps 0.3 unit margin against shifted edges
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         rx_q   <= frame_pkg::RX_IDLE;
         prev_q <= frame_pkg::LINE_HIGH;
         rcnt_q <= 16'h0000;
         rbit_q <= 4'h0;
         rsh_q  <= 8'h00;
      end else begin
         rx_q   <= rx_d;
         prev_q <= line;
         if (rx_q != frame_pkg::RX_RUN || r_end) begin
            rcnt_q <= 16'h0000;
         end else begin
            rcnt_q <= rcnt_q + 16'h0001;
         end
         if (rx_q != frame_pkg::RX_RUN) begin
            rbit_q <= 4'h0;
         end else if (r_end) begin
            rbit_q <= rbit_q + 4'h1;
         end
         if (r_samp && rbit_q != 4'h0 && rbit_q != frame_pkg::PARITY_BIT) begin
            rsh_q <= {line, rsh_q[7:1]};
         end
      end
   end

   // result outputs: one-cycle pulse with data and parity verdict
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         RX_DATA       <= 8'h00;
         RX_VALID      <= 1'b0;
         RX_PARITY_ERR <= 1'b0;
      end else begin
         RX_VALID <= r_done;
         if (r_done) begin
            RX_DATA       <= msb_q ? rx_rev : rsh_q;
            RX_PARITY_ERR <= ^{rsh_q, line};
         end
      end
   end

endmodule
`default_nettype wire

// File: core/terminal_side_end.sv
// terminal end of the character link; learns bit order from the first character
`timescale 1ns/1ps
`default_nettype none
module terminal_side_end (
   input  wire logic                        CORE_CLK,
   input  wire logic                        RESET,
   frame_if.term                            LINK,
   input  wire logic [frame_pkg::ETU_W-1:0] ETU_CYCLES,
   input  wire logic [7:0]                  TX_DATA,
   input  wire logic                        TX_VALID,
   output logic                             TX_READY,
   output logic [7:0]                       RX_DATA,
   output logic                             RX_VALID,
   output logic                             RX_PARITY_ERR,
   output logic                             ORDER_MSB
);

   ////////////////////////////////////////////////////////////////////////////
   // shared decode
   logic                        line;
   logic                        prev_q;
   logic                        fall;
   logic [frame_pkg::ETU_W-1:0] etu_last;
   logic [frame_pkg::ETU_W-1:0] etu_half;
   logic                        known_q;
   logic                        msb_q;

   assign line     = LINK.io_level;
   assign fall     = prev_q & ~line;
   assign etu_last = ETU_CYCLES - 16'h0001;
   assign etu_half = ETU_CYCLES >> 1;

   ////////////////////////////////////////////////////////////////////////////
   // transmitter
   frame_pkg::tx_state_t        tx_q;
   frame_pkg::tx_state_t        tx_d;
   logic [frame_pkg::ETU_W-1:0] tcnt_q;
   logic [3:0]                  tbit_q;
   logic [7:0]                  tsh_q;
   logic                        tpar_q;
   logic                        t_end;
   logic                        t_go;
   logic                        t_level;
   logic                        rx_busy;
   logic [7:0]                  tx_rev;

   assign t_end   = (tcnt_q == etu_last);
   assign t_go    = TX_READY & TX_VALID & line & ~rx_busy;
   assign tx_rev  = {<<{TX_DATA}};
   assign t_level = (tbit_q == 4'h0) ? 1'b0 :
                    (tbit_q == frame_pkg::PARITY_BIT) ? tpar_q : tsh_q[0];

   // next transmit state
   always_comb begin
      tx_d = tx_q;
      case (tx_q)
         frame_pkg::TX_IDLE:  if (t_go) tx_d = frame_pkg::TX_SEND;
         frame_pkg::TX_SEND:  if (t_end && tbit_q == frame_pkg::PARITY_BIT) tx_d = frame_pkg::TX_GUARD;
         frame_pkg::TX_GUARD: if (t_end && tbit_q == frame_pkg::GUARD_ETU - 4'h1) tx_d = frame_pkg::TX_IDLE;
         default:             tx_d = frame_pkg::TX_IDLE;
      endcase
   end

   // bit timer and data shift
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         tx_q   <= frame_pkg::TX_IDLE;
         tcnt_q <= 16'h0000;
         tbit_q <= 4'h0;
         tsh_q  <= 8'h00;
         tpar_q <= 1'b0;
      end else begin
         tx_q   <= tx_d;
         // the taking edge is the first cycle of the start bit
         tcnt_q <= t_go ? 16'h0001 :
                   (tx_q == frame_pkg::TX_IDLE || t_end) ? 16'h0000 : tcnt_q + 16'h0001;
         if (tx_q != tx_d) begin
            tbit_q <= 4'h0;
         end else if (t_end) begin
            tbit_q <= tbit_q + 4'h1;
         end
         if (t_go) begin
            tsh_q  <= msb_q ? tx_rev : TX_DATA;
            tpar_q <= ^TX_DATA;
         end else if (tx_q == frame_pkg::TX_SEND && t_end && tbit_q != 4'h0) begin
            tsh_q <= {1'b0, tsh_q[7:1]};
         end
      end
   end

   // driver released in guard and idle; nothing sent before the order is known
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         LINK.term_out  <= 1'b0;
         LINK.term_oe_n <= 1'b1;
         TX_READY       <= 1'b0;
         ORDER_MSB      <= 1'b0;
      end else begin
         LINK.term_out  <= 1'b0;
         LINK.term_oe_n <= ~(t_go | (tx_q == frame_pkg::TX_SEND & ~t_level));
         TX_READY       <= known_q & (tx_d == frame_pkg::TX_IDLE) & ~t_go;
         ORDER_MSB      <= msb_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receiver
   frame_pkg::rx_state_t        rx_q;
   frame_pkg::rx_state_t        rx_d;
   logic [frame_pkg::ETU_W-1:0] rcnt_q;
   logic [3:0]                  rbit_q;
   logic [7:0]                  rsh_q;
   logic                        r_samp;
   logic                        r_fail;
   logic                        r_done;
   logic [7:0]                  rx_rev;

   assign rx_busy = (rx_q != frame_pkg::RX_IDLE);
   assign r_samp  = (rx_q == frame_pkg::RX_RUN) && (rcnt_q == etu_half);
   assign r_fail  = r_samp && (rbit_q == 4'h0) && line;
   assign r_done  = r_samp && (rbit_q == frame_pkg::PARITY_BIT);
   assign rx_rev  = {<<{rsh_q}};

   // next receive state
   always_comb begin
      rx_d = rx_q;
      case (rx_q)
         frame_pkg::RX_IDLE: if (fall && tx_q == frame_pkg::TX_IDLE && !t_go) rx_d = frame_pkg::RX_RUN;
         frame_pkg::RX_RUN:  if (r_fail || r_done) rx_d = frame_pkg::RX_WAIT;
         frame_pkg::RX_WAIT: if (line) rx_d = frame_pkg::RX_IDLE;
         default:            rx_d = frame_pkg::RX_IDLE;
      endcase
   end

   // sampling timer from the start edge, shift in first bit towards lsb
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         rx_q   <= frame_pkg::RX_IDLE;
         prev_q <= frame_pkg::LINE_HIGH;
         rcnt_q <= 16'h0000;
         rbit_q <= 4'h0;
         rsh_q  <= 8'h00;
      end else begin
         rx_q   <= rx_d;
         prev_q <= line;
         rcnt_q <= (rx_q != frame_pkg::RX_RUN || rcnt_q == etu_last) ? 16'h0000 : rcnt_q + 16'h0001;
         if (rx_q != frame_pkg::RX_RUN) begin
            rbit_q <= 4'h0;
         end else if (rcnt_q == etu_last) begin
            rbit_q <= rbit_q + 4'h1;
         end
         if (r_samp && rbit_q != 4'h0 && rbit_q != frame_pkg::PARITY_BIT) begin
            rsh_q <= {line, rsh_q[7:1]};
         end
      end
   end

   // first character after reset sets the order for the rest of the session
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         known_q       <= 1'b0;
         msb_q         <= 1'b0;
         RX_DATA       <= 8'h00;
         RX_VALID      <= 1'b0;
         RX_PARITY_ERR <= 1'b0;
      end else begin
         RX_VALID <= r_done;
         if (r_done) begin
            known_q       <= 1'b1;
            RX_PARITY_ERR <= ^{rsh_q, line};
            if (!known_q) begin
               msb_q   <= (rsh_q != frame_pkg::CONV_DIRECT);
               RX_DATA <= (rsh_q == frame_pkg::CONV_DIRECT) ? rsh_q : rx_rev;
            end else begin
               RX_DATA <= msb_q ? rx_rev : rsh_q;
            end
         end
      end
   end

endmodule
`default_nettype wire

// File: verif/character_frame_io_asserts.sv
// concurrent checks on the shared character line between the two ends
`timescale 1ns/1ps
`default_nettype none
module character_frame_io_asserts (
   input wire logic                        CORE_CLK,
   input wire logic                        RESET,
   input wire logic [frame_pkg::ETU_W-1:0] ETU_CYCLES,
   input wire logic                        card_out,
   input wire logic                        card_oe_n,
   input wire logic                        term_out,
   input wire logic                        term_oe_n,
   input wire logic                        io_level
);
   logic        act_q;
   logic        act_d;
   logic [19:0] cnt_q;
   logic [19:0] cnt_d;
   logic        par_q;
   logic        par_d;
   wire  [19:0] unit_w = {4'h0, ETU_CYCLES};
   wire         start_w = !act_q && !io_level;
   wire         mid_w = act_q && (cnt_q % unit_w == (unit_w >> 1)) && (cnt_q > unit_w);
   wire  [19:0] end_w = 20'hA * unit_w;

   ////////////////////////////////////////
   // frame tracker: counts cycles from a fall seen on an idle line, folds mid-unit samples into parity
   assign act_d = start_w | (act_q && cnt_q != 20'hC * unit_w - 20'h1);
   assign cnt_d = start_w ? 20'h1 : (act_q ? cnt_q + 20'h1 : 20'h0);
   assign par_d = start_w ? 1'b0 : (mid_w ? par_q ^ io_level : par_q);

   // tracker registers
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         act_q <= 1'b0;
         cnt_q <= 20'h0;
         par_q <= 1'b0;
      end else begin
         act_q <= act_d;
         cnt_q <= cnt_d;
         par_q <= par_d;
      end
   end

   ////////////////////////////////////////
   // one clock domain, so clocking and disable are given once
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RESET);

   a_card_idle_start: assert property ($fell(card_oe_n) |-> $past(io_level))
      else $error("card pulled the line while it was not idle");
   a_term_idle_start: assert property ($fell(term_oe_n) |-> $past(io_level))
      else $error("terminal pulled the line while it was not idle");
   a_start_low: assert property (act_q && cnt_q < unit_w |-> !io_level)
      else $error("start bit shorter than one unit");
   a_edge_on_unit: assert property (act_q && cnt_q % unit_w != 20'h0 && cnt_q < end_w |-> $stable(io_level))
      else $error("line changed off a unit boundary");
   a_even_parity: assert property (act_q && cnt_q == end_w |-> !par_q)
      else $error("odd count of ones in data and parity");
   a_guard_quiet: assert property (act_q && cnt_q >= end_w |-> io_level && card_oe_n && term_oe_n)
      else $error("line driven during guard time");
   a_frame_release: assert property (act_q && cnt_q == end_w - 20'h1 |=> io_level [*8])
      else $error("line not released after ten units");
   a_one_talker: assert property ((card_oe_n | card_out) | (term_oe_n | term_out))
      else $error("both ends pulling the line at once");
endmodule
`default_nettype wire

// File: verif/character_frame_io_test.sv
// self-checking bench: both ends on one line, and a second card end fed by a skewed driver
`timescale 1ns/1ps
`default_nettype none
module character_frame_io_test;
   localparam logic [15:0] E = 16'h000A; // ten cycles a unit, so 0.2 unit is two cycles
   localparam logic [7:0]  DATA [12] = '{8'h55, 8'hAA, 8'h0F, 8'h00, 8'hF0, 8'hFF,
                                         8'h00, 8'hF0, 8'hFF, 8'h00, 8'hF0, 8'hFF};
   logic       core_clk, reset, ms, c_txv, t_txv, c_rdy, t_rdy, t_oe2_n, w_act;
   logic       c_rxv, t_rxv, c2_rxv, c_err, t_err, c2_err, c_ord, t_ord;
   logic [7:0] c_txd, t_txd, c_rxd, t_rxd, c2_rxd, wb;
   logic [9:0] w_bits;
   logic [31:0] u;
   logic [8:0] exp_t[$], exp_c[$], exp_c2[$], exp_w[$];
   int         failures, tests_run, cyc, w_cnt;
   frame_if lnk();
   frame_if lnk2();

   ////////////////////////////////////////
   // both ends face each other; the second card end listens to the bench
   card_device_end card_device_end_inst (.CORE_CLK(core_clk), .RESET(reset), .LINK(lnk.card), .ETU_CYCLES(E),
      .MSB_FIRST(ms), .TX_DATA(c_txd), .TX_VALID(c_txv), .TX_READY(c_rdy), .RX_DATA(c_rxd), .RX_VALID(c_rxv),
      .RX_PARITY_ERR(c_err), .ORDER_MSB(c_ord));
   terminal_side_end terminal_side_end_inst (.CORE_CLK(core_clk), .RESET(reset), .LINK(lnk.term), .ETU_CYCLES(E),
      .TX_DATA(t_txd), .TX_VALID(t_txv), .TX_READY(t_rdy), .RX_DATA(t_rxd), .RX_VALID(t_rxv),
      .RX_PARITY_ERR(t_err), .ORDER_MSB(t_ord));
   card_device_end card_device_end_inst_b (.CORE_CLK(core_clk), .RESET(reset), .LINK(lnk2.card), .ETU_CYCLES(E),
      .MSB_FIRST(ms), .TX_DATA(8'h00), .TX_VALID(1'b0), .TX_READY(), .RX_DATA(c2_rxd), .RX_VALID(c2_rxv),
      .RX_PARITY_ERR(c2_err), .ORDER_MSB());
   assign lnk2.term_out = 1'b0;
   assign lnk2.term_oe_n = t_oe2_n;
   character_frame_io_asserts character_frame_io_asserts_inst (.CORE_CLK(core_clk), .RESET(reset),
      .ETU_CYCLES(E), .card_out(lnk.card_out), .card_oe_n(lnk.card_oe_n), .term_out(lnk.term_out),
      .term_oe_n(lnk.term_oe_n), .io_level(lnk.io_level));

   // clock and hang limit; the limit is well above two full passes
   always #2 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 30000) begin
         failures++;
         wrap_up;
      end
   end

   ////////////////////////////////////////
   task automatic chk(input string w, input logic [8:0] e, input logic [8:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", w, e, g);
      end
   endtask

   task wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task wait_rdy(input logic side);
      for (int n = 0; n < 3000 && (side ? t_rdy : c_rdy) !== 1'b1; n++) @(negedge core_clk);
   endtask

   // request held until the end drops its ready, which marks the taking edge
   task send(input logic side, input logic [7:0] v);
      wait_rdy(side);
      if (side) begin
         t_txd = v;
         t_txv = 1'b1;
         exp_c.push_back({1'b0, v});
      end else begin
         c_txd = v;
         c_txv = 1'b1;
         exp_t.push_back({1'b0, v});
      end
      exp_w.push_back({1'b0, v});
      for (int n = 0; n < 300 && (side ? t_rdy : c_rdy) !== 1'b0; n++) @(negedge core_clk);
      c_txv = 1'b0;
      t_txv = 1'b0;
   endtask

   // bench plays the terminal on the second line: all edges after the start moved by sh cycles
   task skew_send(input logic [7:0] v, input int sh, input logic bad);
      logic [9:0] f;
      f[0] = 1'b0;
      for (int k = 0; k < 8; k++) f[k + 1] = ms ? v[7 - k] : v[k];
      f[9] = ^v ^ bad;
      exp_c2.push_back({bad, v});
      for (int k = 0; k < 10; k++) begin
         t_oe2_n = f[k];
         repeat (k == 0 ? E + sh : E) @(negedge core_clk);
      end
      t_oe2_n = 1'b1;
      repeat (3 * E) @(negedge core_clk);
   endtask

   task do_reset(input logic m);
      reset = 1'b1;
      ms = m;
      exp_t.delete();
      exp_c.delete();
      exp_c2.delete();
      exp_w.delete();
      exp_w.push_back({1'b0, m ? frame_pkg::CONV_INVERSE : frame_pkg::CONV_DIRECT});
      exp_t.push_back({1'b0, m ? frame_pkg::CONV_INVERSE : frame_pkg::CONV_DIRECT});
      repeat (3) @(negedge core_clk);
      reset = 1'b0;
   endtask

   ////////////////////////////////////////
   // receive side model: each delivered byte must be the next one queued for that end
   always @(posedge core_clk) if (!reset) begin
      if (t_rxv) chk("term rx", exp_t.size() ? exp_t.pop_front() : 9'h1FF, {t_err, t_rxd});
      if (c_rxv) chk("card rx", exp_c.size() ? exp_c.pop_front() : 9'h1FF, {c_err, c_rxd});
      if (c2_rxv) chk("skew rx", exp_c2.size() ? exp_c2.pop_front() : 9'h1FF, {c2_err, c2_rxd});
   end

   // line decoder: samples mid-unit from each start it sees, independent of both ends
   always @(posedge core_clk) begin
      if (reset) w_act = 1'b0;
      else if (!w_act && !lnk.io_level) begin
         w_act = 1'b1;
         w_cnt = 1;
      end else if (w_act) begin
         if (w_cnt % E == E / 2 && w_cnt < 10 * E) w_bits[w_cnt / E] = lnk.io_level;
         if (w_cnt == 10 * E) begin
            for (int k = 0; k < 8; k++) wb[k] = ms ? w_bits[8 - k] : w_bits[k + 1];
            chk("line start", 9'h000, {8'h00, w_bits[0]});
            chk("line parity", 9'h000, {8'h00, ^w_bits[9:1]});
            chk("line byte", exp_w.size() ? exp_w.pop_front() : 9'h1FF, {1'b0, wb});
         end
         w_cnt++;
         if (w_cnt == 12 * E) w_act = 1'b0;
      end
   end

   ////////////////////////////////////////
   // main sequence: one pass for each bit order, reset again in mid-run
   initial begin
      core_clk = 0;
      reset = 1'b1;
      {ms, c_txv, t_txv, c_txd, t_txd} = '0;
      t_oe2_n = 1'b1;
      failures = 0;
      tests_run = 0;
      cyc = 0;
      void'($urandom(32'hA2C6CD3F));
      for (int m = 0; m < 2; m++) begin
         do_reset(m[0]);
         wait_rdy(1'b1);
         chk("card order", {8'h00, m[0]}, {8'h00, c_ord});
         chk("term order", {8'h00, m[0]}, {8'h00, t_ord});
         foreach (DATA[k]) send(1'b0, DATA[k]);
         u = $urandom;
         send(1'b0, u[15:8]);
         send(1'b0, u[7:0]);
         wait_rdy(1'b0);
         for (int k = 0; k < 6; k++) begin
            u = $urandom;
            send(1'b1, u[7:0]);
         end
         wait_rdy(1'b1);
         t_oe2_n = 1'b0;
         repeat (3) @(negedge core_clk);
         t_oe2_n = 1'b1;
         repeat (2 * E) @(negedge core_clk);
         u = $urandom;
         skew_send(u[7:0], 2, 1'b0);
         skew_send(u[15:8], -2, 1'b0);
         skew_send(u[23:16], 0, 1'b1);
         repeat (2 * E) @(negedge core_clk);
         chk("left over", 9'h000, 9'(exp_t.size() + exp_c.size() + exp_c2.size() + exp_w.size()));
         $display("pass with msb order %0d done", m);
      end
      wrap_up;
   end
endmodule
`default_nettype wire
